// [pkg/ipsw_defs.svh]
// Offsets, field codes, reset values and timing counts of the
// interrupt priority and standby block.
// Assumes a 40 MHz system clock and an 8-bit register port.
`ifndef IPSW_DEFS_SVH
`define IPSW_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define IPSW_A_CTRL   4'h0
`define IPSW_A_FLAG   4'h1
`define IPSW_A_IEL    4'h2
`define IPSW_A_IEH    4'h3
`define IPSW_A_PRL    4'h4
`define IPSW_A_PRH    4'h5
`define IPSW_A_P0M    4'h6
`define IPSW_A_STBY   4'h7

// ************************************************************
// Trigger mode codes and standby command bits
// ************************************************************
`define IPSW_MODE_RISE 2'h0
`define IPSW_MODE_FALL 2'h1
`define IPSW_MODE_HIGH 2'h2
`define IPSW_MODE_LOW  2'h3
`define IPSW_STBY_PAUSE 0
`define IPSW_STBY_OSTOP 1

// ************************************************************
// Reset values and vector layout
// ************************************************************
`define IPSW_RST_BYTE  8'h00
`define IPSW_RST_VEC10 10'h000
`define IPSW_VEC_BASE  8'h03
`define IPSW_NUM_VEC   10

// ************************************************************
// Timing
// ************************************************************
`define IPSW_CLK_NS  25
`define IPSW_FILT_NS 1000
`define IPSW_FILT_CYC ((`IPSW_FILT_NS + `IPSW_CLK_NS - 1) / `IPSW_CLK_NS)

`endif

// [pkg/ipsw_pkg.sv]
// Types shared by the interrupt priority and standby block.
// Assumes the constants header is compiled alongside.
`default_nettype none

package ipsw_pkg;

  // ************************************************************
  // Standby states, one-hot
  // ************************************************************
  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_PAUSE = 3'h2,
    ST_OSTOP = 3'h4
  } ipsw_state_t;

  // Priority levels, low to highest
  typedef enum logic [1:0] {
    LV_LOW  = 2'h0,
    LV_HIGH = 2'h1,
    LV_TOP  = 2'h2
  } ipsw_level_t;

  // Request presented to the processor core
  typedef struct packed {
    logic        req;
    ipsw_level_t lvl;
    logic [7:0]  vec;
  } ipsw_irq_t;

endpackage

`default_nettype wire

// [hdl/ipsw_noise_filter.sv]
// Noise rejection filter for the fourth external interrupt pin.
// Assumes the pin is synchronous to the clock and reset is synced.
`default_nettype none
`include "ipsw_defs.svh"

module ipsw_noise_filter (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output var  logic pin_out
);

  localparam logic [5:0] FILT_CYC = 6'(`IPSW_FILT_CYC);

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic       out_reg;
  wire        differs = pin_in ^ out_reg;

  // Count consecutive samples that differ from the accepted level
  assign cnt_next = differs ? (cnt_reg + 6'h01) : 6'h00;

  // Short glitches never reach the count and are dropped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 6'h00;
      out_reg <= 1'b0;
    end else if (differs && cnt_next >= FILT_CYC) begin
      cnt_reg <= 6'h00;
      out_reg <= pin_in;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign pin_out = out_reg;

endmodule

`default_nettype wire

// [hdl/ipsw_irq_standby.sv]
// Interrupt priority, external interrupt pins and standby control.
// Assumes pins and core handshakes are synchronous to ref_clk_in.
//
// Overview of operation
// - Three priority levels, low, high, highest, decide among pending requests.
// - A higher level request may interrupt a running lower level handler.
// - Vectors three to ten take low or high priority, never highest.
// - First two external pins take low or highest priority, never high.
// - Pause standby stops execution while oscillators keep running.
// - Pause standby ends on any enabled interrupt request or a system reset.
// - Oscillator-stop standby halts the RC oscillator, VCO and crystal.
// - Oscillator-stop standby ends when the reset pin goes low.
// - Oscillator-stop ends on the selected level at external pin a or b.
// - Oscillator-stop ends on the enabled port 0 interrupt condition.
// - Pins a and b: rise, fall, high, low; vectors 03H and 0BH.
// - Pins c and d: rise, fall, both; vectors 13H, 1BH; feed timer.
// - Pin d passes a noise rejection filter before edge detection.
// - Pin c shares with timer low byte, pin d with base timer.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`default_nettype none
`include "ipsw_defs.svh"

module ipsw_irq_standby (
  input  wire logic              ref_clk_in,
  input  wire logic              reset_n_in,
  input  wire logic [3:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output var  logic [7:0]        reg_rdata_out,
  input  wire logic              port7_bit0_in,
  input  wire logic              port7_bit1_in,
  input  wire logic              port7_bit2_in,
  input  wire logic              port7_bit3_in,
  input  wire logic [7:0]        port0_pins_in,
  input  wire logic              t0l_evt_in,
  input  wire logic              btm_evt_in,
  input  wire logic [5:0]        periph_req_in,
  input  wire logic              core_ack_in,
  input  wire logic              core_reti_in,
  output var  ipsw_pkg::ipsw_irq_t core_irq_out,
  output var  logic              timer_evt_out,
  output var  logic              cpu_run_out,
  output var  logic [2:0]        osc_en_out
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_reg;
  wire        rst_n = rst_sync_reg[1];

  // Release through two flops so every register leaves reset together
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // ************************************************************
  // Registers and decode
  // ************************************************************
  logic [7:0] ctrl_reg;
  logic [6:0] flag_reg;
  logic [6:0] flag_next;
  logic [9:0] ie_reg;
  logic [9:0] pri_reg;
  logic [7:0] p0m_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  wire wr_ctrl = reg_wr_in && (reg_addr_in == `IPSW_A_CTRL);
  wire wr_flag = reg_wr_in && (reg_addr_in == `IPSW_A_FLAG);
  wire wr_iel  = reg_wr_in && (reg_addr_in == `IPSW_A_IEL);
  wire wr_ieh  = reg_wr_in && (reg_addr_in == `IPSW_A_IEH);
  wire wr_prl  = reg_wr_in && (reg_addr_in == `IPSW_A_PRL);
  wire wr_prh  = reg_wr_in && (reg_addr_in == `IPSW_A_PRH);
  wire wr_p0m  = reg_wr_in && (reg_addr_in == `IPSW_A_P0M);
  wire wr_stby = reg_wr_in && (reg_addr_in == `IPSW_A_STBY);

  // Configuration registers
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `IPSW_RST_BYTE;
      ie_reg   <= `IPSW_RST_VEC10;
      pri_reg  <= `IPSW_RST_VEC10;
      p0m_reg  <= `IPSW_RST_BYTE;
    end else begin
      if (wr_ctrl) ctrl_reg <= reg_wdata_in;
      if (wr_iel) ie_reg[7:0] <= reg_wdata_in;
      if (wr_ieh) ie_reg[9:8] <= reg_wdata_in[1:0];
      if (wr_prl) pri_reg[7:0] <= reg_wdata_in;
      if (wr_prh) pri_reg[9:8] <= reg_wdata_in[1:0];
      if (wr_p0m) p0m_reg <= reg_wdata_in;
    end
  end

  // ************************************************************
  // External interrupt pins
  // ************************************************************
  logic       ext_irq_d_filtered;
  logic [3:0] pin_prev_reg;
  logic       arm_reg;
  logic [3:0] ext_hit;
  logic [1:0] wake_ab;

  // Pin d is cleaned before any edge is looked for
  ipsw_noise_filter u_filt (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n),
    .pin_in   (port7_bit3_in),
    .pin_out  (ext_irq_d_filtered)
  );

  wire [3:0] pin_now = {ext_irq_d_filtered, port7_bit2_in,
                        port7_bit1_in, port7_bit0_in};

  // Edges are ignored in the first cycle, before a sample is held
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_reg <= 4'h0;
      arm_reg      <= 1'b0;
    end else begin
      pin_prev_reg <= pin_now;
      arm_reg      <= 1'b1;
    end
  end

  // Trigger decode per pin; pins a and b know levels, c and d both edges
  genvar g;
  for (g = 0; g < 4; g++) begin : g_pin
    wire [1:0] mode = ctrl_reg[2*g+1:2*g];
    wire rise = arm_reg & pin_now[g] & ~pin_prev_reg[g];
    wire fall = arm_reg & ~pin_now[g] & pin_prev_reg[g];
    if (g < 2) begin : g_lvl
      assign ext_hit[g] = ((mode == `IPSW_MODE_RISE) & rise) |
                          ((mode == `IPSW_MODE_FALL) & fall) |
                          ((mode == `IPSW_MODE_HIGH) & pin_now[g]) |
                          ((mode == `IPSW_MODE_LOW) & ~pin_now[g]);
      // Edge modes wake on the level the edge leads to
      assign wake_ab[g] = ie_reg[g] & (pin_now[g] ^ mode[0]);
    end else begin : g_edge
      // Codes two and three both mean either edge; no level mode exists
      assign ext_hit[g] = ((mode == `IPSW_MODE_RISE) & rise) |
                          ((mode == `IPSW_MODE_FALL) & fall) |
                          (mode[1] & (rise | fall));
    end
  end

  // ************************************************************
  // Flags and per-vector requests
  // ************************************************************
  wire port0_cond = |(~port0_pins_in & p0m_reg); // Low on an enabled pin
  wire [6:0] flag_set = {port0_cond, btm_evt_in, t0l_evt_in, ext_hit};
  wire [6:0] flag_clr = wr_flag ? reg_wdata_in[6:0] : 7'h00;

  // Write one to clear; a new event in the same cycle survives the clear
  assign flag_next = flag_set | (flag_reg & ~flag_clr);

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 7'h00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Shared vectors: handler tells sources apart by their flags
  wire [9:0] src_req = {periph_req_in[5] | flag_reg[6],
                        periph_req_in[4:0],
                        flag_reg[3] | flag_reg[5],
                        flag_reg[2] | flag_reg[4],
                        flag_reg[1:0]};
  wire [9:0] req_vec = src_req & ie_reg;
  wire       any_req = |req_vec;

  logic [9:0] pend_top;
  logic [9:0] pend_high;
  logic [9:0] pend_low;

  // Level of each vector; the level pattern depends on the vector number
  genvar v;
  for (v = 0; v < `IPSW_NUM_VEC; v++) begin : g_vec
    if (v < 2) begin : g_ab
      assign pend_top[v]  = req_vec[v] & pri_reg[v];
      assign pend_high[v] = 1'b0;
    end else begin : g_rest
      assign pend_top[v]  = 1'b0;
      assign pend_high[v] = req_vec[v] & pri_reg[v];
    end
    assign pend_low[v] = req_vec[v] & ~pri_reg[v];
  end

  // ************************************************************
  // Priority resolution and nesting
  // ************************************************************
  logic [2:0]          isr_reg;
  logic [2:0]          isr_next;
  ipsw_pkg::ipsw_irq_t irq_reg;
  ipsw_pkg::ipsw_irq_t irq_next;

  // Lowest set index of a mask, with a found bit on top
  function automatic logic [4:0] first_set(input logic [9:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 9; k >= 0; k--) begin
      if (m[k]) r = {1'b1, 4'(k)};
    end
    return r;
  endfunction

  wire [4:0] pick_top  = first_set(pend_top);
  wire [4:0] pick_high = first_set(pend_high);
  wire [4:0] pick_low  = first_set(pend_low);

  // A level may be taken only above every level in service
  wire ok_top  = ~isr_reg[2];
  wire ok_high = ~isr_reg[2] & ~isr_reg[1];
  wire ok_low  = ~|isr_reg;

  // Highest allowed level with a pending request wins
  always_comb begin
    irq_next = '0;
    if (pick_top[4] && ok_top) begin
      irq_next.req = 1'b1;
      irq_next.lvl = ipsw_pkg::LV_TOP;
      irq_next.vec = `IPSW_VEC_BASE + {1'b0, pick_top[3:0], 3'h0};
    end else if (pick_high[4] && ok_high) begin
      irq_next.req = 1'b1;
      irq_next.lvl = ipsw_pkg::LV_HIGH;
      irq_next.vec = `IPSW_VEC_BASE + {1'b0, pick_high[3:0], 3'h0};
    end else if (pick_low[4] && ok_low) begin
      irq_next.req = 1'b1;
      irq_next.lvl = ipsw_pkg::LV_LOW;
      irq_next.vec = `IPSW_VEC_BASE + {1'b0, pick_low[3:0], 3'h0};
    end
  end

  wire       take = core_ack_in & irq_reg.req;
  wire [2:0] take_oh = (irq_reg.lvl == ipsw_pkg::LV_TOP)  ? 3'h4 :
                       (irq_reg.lvl == ipsw_pkg::LV_HIGH) ? 3'h2 : 3'h1;
  wire [2:0] ret_oh  = isr_reg[2] ? 3'h4 : isr_reg[1] ? 3'h2 : 3'h1;

  // Return retires the deepest level, then an accept marks a new one
  always_comb begin
    isr_next = isr_reg;
    if (core_reti_in) isr_next = isr_next & ~ret_oh;
    if (take) isr_next = isr_next | take_oh;
  end

  // An accepted request is withdrawn at once so it cannot be taken twice
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      isr_reg <= 3'h0;
      irq_reg <= '0;
    end else begin
      isr_reg <= isr_next;
      irq_reg <= take ? '0 : irq_next;
    end
  end

  assign core_irq_out = irq_reg;

  // ************************************************************
  // Standby control
  // ************************************************************
  ipsw_pkg::ipsw_state_t state_reg;
  ipsw_pkg::ipsw_state_t state_next;
  logic                  run_reg;
  logic [2:0]            osc_reg;
  logic                  tev_reg;

  wire p0_wake = port0_cond & ie_reg[9];

  // Reset pin low forces run through the async reset path
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ipsw_pkg::ST_RUN: begin
        if (wr_stby && reg_wdata_in[`IPSW_STBY_OSTOP]) begin
          state_next = ipsw_pkg::ST_OSTOP;
        end else if (wr_stby && reg_wdata_in[`IPSW_STBY_PAUSE]) begin
          state_next = ipsw_pkg::ST_PAUSE;
        end
      end
      ipsw_pkg::ST_PAUSE: begin
        if (any_req) state_next = ipsw_pkg::ST_RUN;
      end
      ipsw_pkg::ST_OSTOP: begin
        if (|wake_ab || p0_wake) state_next = ipsw_pkg::ST_RUN;
      end
      default: state_next = ipsw_pkg::ST_RUN;
    endcase
  end

  // Outputs follow the state they will show, so they stay in step
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ipsw_pkg::ST_RUN;
      run_reg   <= 1'b1;
      osc_reg   <= 3'h7;
      tev_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      run_reg   <= (state_next == ipsw_pkg::ST_RUN);
      osc_reg   <= (state_next == ipsw_pkg::ST_OSTOP) ? 3'h0 : 3'h7;
      tev_reg   <= ext_hit[2] | ext_hit[3];
    end
  end

  assign cpu_run_out   = run_reg;
  assign osc_en_out    = osc_reg;
  assign timer_evt_out = tev_reg;

  // ************************************************************
  // Read back
  // ************************************************************
  // Unmapped addresses read as zero; reads have no side effects
  always_comb begin
    unique case (reg_addr_in)
      `IPSW_A_CTRL: rdata_next = ctrl_reg;
      `IPSW_A_FLAG: rdata_next = {1'b0, flag_reg};
      `IPSW_A_IEL:  rdata_next = ie_reg[7:0];
      `IPSW_A_IEH:  rdata_next = {6'h00, ie_reg[9:8]};
      `IPSW_A_PRL:  rdata_next = pri_reg[7:0];
      `IPSW_A_PRH:  rdata_next = {6'h00, pri_reg[9:8]};
      `IPSW_A_P0M:  rdata_next = p0m_reg;
      `IPSW_A_STBY: rdata_next = {2'h0, state_reg, isr_reg};
      default:      rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_rd_in ? rdata_next : 8'h00;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  AST_LEVEL_TOP_FIRST: assert property (
    (pick_top[4] && ok_top && !take) |=> (irq_reg.req && irq_reg.lvl == ipsw_pkg::LV_TOP)
  ) else $error("Highest level request not presented first");

  AST_NEST_OVER_LOW: assert property (
    (take && irq_reg.lvl == ipsw_pkg::LV_TOP && (|isr_reg[1:0]) && !core_reti_in)
    |=> (isr_reg == ($past(isr_reg) | 3'h4))
  ) else $error("Nested accept did not keep both levels in service");

  AST_NO_TOP_LATE_VEC: assert property (
    (irq_reg.req && irq_reg.vec >= 8'h13) |-> (irq_reg.lvl != ipsw_pkg::LV_TOP)
  ) else $error("Vector above 0BH presented at highest level");

  AST_NO_HIGH_AB: assert property (
    (irq_reg.req && irq_reg.vec <= 8'h0b) |-> (irq_reg.lvl != ipsw_pkg::LV_HIGH)
  ) else $error("Pin a or b presented at high level");

  AST_PAUSE_HALTS: assert property (
    (state_reg == ipsw_pkg::ST_PAUSE) |-> (!cpu_run_out && osc_en_out == 3'h7)
  ) else $error("Pause did not halt the core with oscillators on");

  AST_PAUSE_WAKE: assert property (
    (state_reg == ipsw_pkg::ST_PAUSE && any_req)
    |=> (state_reg == ipsw_pkg::ST_RUN) ##0 cpu_run_out
  ) else $error("Request did not end pause");

  AST_OSTOP_OFF: assert property (
    (state_reg == ipsw_pkg::ST_OSTOP) |-> (osc_en_out == 3'h0 && !cpu_run_out)
  ) else $error("Oscillators running in oscillator-stop");

  AST_OSTOP_PIN_WAKE: assert property (
    (state_reg == ipsw_pkg::ST_OSTOP && |wake_ab)
    |=> (osc_en_out == 3'h7)
  ) else $error("Pin a or b did not end oscillator-stop");

  AST_OSTOP_P0_WAKE: assert property (
    (state_reg == ipsw_pkg::ST_OSTOP && p0_wake)
    |=> (state_reg == ipsw_pkg::ST_RUN)
  ) else $error("Port 0 condition did not end oscillator-stop");

  AST_TIMER_FEED: assert property (
    $rose(ext_hit[2]) |=> timer_evt_out
  ) else $error("Pin c edge not passed to the timer");

  AST_LOW_VEC_FIRST: assert property (
    (pend_low[0] && !pick_top[4] && !pick_high[4] && ok_low && !take)
    |=> (irq_reg.req && irq_reg.vec == 8'h03)
  ) else $error("Lower vector not served first");

endmodule

`default_nettype wire

// [test/ipsw_core_model.sv]
// Behavioural processor core that takes the presented request.
// Assumes the request struct is registered on the rising edge of clk_in.
`default_nettype none

module ipsw_core_model (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire ipsw_pkg::ipsw_irq_t irq_in,
  input  wire logic                auto_ack_in,
  input  wire logic [3:0]          ack_dly_in,
  output var  logic                ack_out,
  output var  ipsw_pkg::ipsw_irq_t taken_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] wait_reg;

  // ************************************************************
  // Acceptance
  // ************************************************************
  // Waits ack_dly_in cycles so a slow core is exercised as well as a prompt one;
  // the ack is never raised while no request stands, as a real core would not
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out   <= 1'b0;
      wait_reg  <= 4'h0;
      taken_out <= '0;
    end else begin
      ack_out <= 1'b0;
      if (ack_out && irq_in.req) begin
        taken_out <= irq_in;  // What the core really vectors to
      end
      if (auto_ack_in && irq_in.req && !ack_out) begin
        if (wait_reg == ack_dly_in) begin
          ack_out  <= 1'b1;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

// [test/irq_priority_standby_wake_tb_top.sv]
// Self-checking bench of the interrupt priority and standby block.
// Assumes the package, the design files and the core model compile first.
`default_nettype none
`include "ipsw_defs.svh"

module irq_priority_standby_wake_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic [3:0]          addr = 4'h0;
  logic [7:0]          wdata = 8'h00;
  logic                wr_s = 1'b0;
  logic                rd_s = 1'b0;
  logic [7:0]          rdata;
  logic [3:0]          p7 = 4'h0;
  logic [7:0]          p0 = 8'hff;
  logic                t0l = 1'b0;
  logic                btm = 1'b0;
  logic [5:0]          preq = 6'h00;
  logic                ack;
  logic                reti = 1'b0;
  logic                auto = 1'b0;
  logic [3:0]          dly = 4'h0;
  ipsw_pkg::ipsw_irq_t irq;
  ipsw_pkg::ipsw_irq_t taken;
  logic                tevt;
  logic                run;
  logic [2:0]          osc;
  int                  n_mismatch = 0;
  int                  n_checks = 0;
  int                  n_evt = 0;
  logic [19:0]         rows [7];

  always #12.5 clk = ~clk;
  // Timer event pulses are counted so edge modes can be judged by totals
  always @(posedge clk) if (tevt === 1'b1) n_evt++;

  ipsw_irq_standby DUT (.ref_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
    .port7_bit0_in(p7[0]), .port7_bit1_in(p7[1]), .port7_bit2_in(p7[2]),
    .port7_bit3_in(p7[3]), .port0_pins_in(p0), .t0l_evt_in(t0l), .btm_evt_in(btm),
    .periph_req_in(preq), .core_ack_in(ack), .core_reti_in(reti), .core_irq_out(irq),
    .timer_evt_out(tevt), .cpu_run_out(run), .osc_en_out(osc));

  ipsw_core_model CORE (.clk_in(clk), .rst_n_in(rst_n), .irq_in(irq), .auto_ack_in(auto),
    .ack_dly_in(dly), .ack_out(ack), .taken_out(taken));

  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe; look mid-cycle, then
  // return on a rising edge so later stimulus stays on the clock
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask
  task automatic reti_p;
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well past the expected run of about 550 cycles
  initial begin
    cyc(20000);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rows = '{20'h0_a5_a5, 20'h2_ff_ff, 20'h3_03_03, 20'h4_c3_c3, 20'h5_02_02,
             20'h6_5a_5a, 20'h9_ff_00};
    cyc(8);
    chk({3'h0, rdata, tevt, run, osc}, 16'h000f);
    chk({5'h0, irq}, 16'h0000);
    rst_n <= 1'b1;
    cyc(3);
    for (int a = 0; a < 8; a++) rd(a[3:0], (a == 7) ? 8'h08 : 8'h00);
    // Table of write, read back and restore; the unmapped row reads zero
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16], rows[i][7:0]);
      wr(rows[i][19:16], 8'h00);
    end
    // Pin a rising edge reaches the core on its own vector
    wr(`IPSW_A_IEL, 8'h01);
    p7[0] <= 1'b1;
    cyc(5);
    chk({5'h0, irq}, {5'h0, 1'b1, ipsw_pkg::LV_LOW, 8'h03});
    auto <= 1'b1;
    cyc(4);
    chk({5'h0, taken}, {5'h0, 1'b1, ipsw_pkg::LV_LOW, 8'h03});
    wr(`IPSW_A_FLAG, 8'h01);
    reti_p;
    wr(`IPSW_A_IEL, 8'h00);
    auto <= 1'b0;
    // Every trigger mode of pin b; the idle level is the inverse of active
    for (int m = 0; m < 4; m++) begin
      p7[1] <= m[0];
      wr(`IPSW_A_CTRL, {4'h0, m[1:0], 2'h0});
      wr(`IPSW_A_FLAG, 8'h02);
      rd(`IPSW_A_FLAG, 8'h00);
      p7[1] <= !m[0];
      cyc(4);
      rd(`IPSW_A_FLAG, 8'h02);
      p7[1] <= m[0];
      cyc(2);
      wr(`IPSW_A_FLAG, 8'h02);
    end
    // Pin c rise, fall and both edges, counted on the timer event output
    for (int m = 0; m < 4; m++) begin
      wr(`IPSW_A_CTRL, {2'h0, m[1:0], 4'h0});
      n_evt = 0;
      p7[2] <= 1'b1;
      cyc(4);
      p7[2] <= 1'b0;
      cyc(4);
      chk(n_evt[15:0], (m >= 2) ? 16'h0002 : 16'h0001);
      rd(`IPSW_A_FLAG, 8'h04);
      wr(`IPSW_A_FLAG, 8'h04);
    end
    // Pin d: a pulse shorter than the filter count is swallowed
    wr(`IPSW_A_CTRL, 8'h00);
    n_evt = 0;
    p7[3] <= 1'b1;
    cyc(20);
    p7[3] <= 1'b0;
    cyc(50);
    rd(`IPSW_A_FLAG, 8'h00);
    p7[3] <= 1'b1;
    cyc(60);
    p7[3] <= 1'b0;
    cyc(50);
    chk(n_evt[15:0], 16'h0001);
    // Timer events share the vectors of pins c and d
    t0l <= 1'b1;
    btm <= 1'b1;
    cyc(1);
    t0l <= 1'b0;
    btm <= 1'b0;
    cyc(3);
    rd(`IPSW_A_FLAG, 8'h38);
    wr(`IPSW_A_IEL, 8'h0c);
    cyc(4);
    chk({5'h0, irq}, {5'h0, 1'b1, ipsw_pkg::LV_LOW, 8'h13});
    wr(`IPSW_A_FLAG, 8'h3f);
    wr(`IPSW_A_IEL, 8'h30);
    // Two low requests, then one raised to high, then a highest nests on top
    p7[0] <= 1'b0;
    preq <= 6'h03;
    cyc(4);
    chk({5'h0, irq}, {5'h0, 1'b1, ipsw_pkg::LV_LOW, 8'h23});
    wr(`IPSW_A_PRL, 8'h20);
    cyc(4);
    chk({5'h0, irq}, {5'h0, 1'b1, ipsw_pkg::LV_HIGH, 8'h2b});
    dly <= 4'h3;
    auto <= 1'b1;
    cyc(8);
    chk({5'h0, taken}, {5'h0, 1'b1, ipsw_pkg::LV_HIGH, 8'h2b});
    preq <= 6'h01;
    cyc(4);
    chk({15'h0, irq.req}, 16'h0000);
    wr(`IPSW_A_PRL, 8'h21);
    wr(`IPSW_A_IEL, 8'h31);
    p7[0] <= 1'b1;
    cyc(10);
    chk({5'h0, taken}, {5'h0, 1'b1, ipsw_pkg::LV_TOP, 8'h03});
    rd(`IPSW_A_STBY, 8'h0e);
    wr(`IPSW_A_FLAG, 8'h01);
    reti_p;
    reti_p;
    cyc(8);
    chk({5'h0, taken}, {5'h0, 1'b1, ipsw_pkg::LV_LOW, 8'h23});
    preq <= 6'h00;
    auto <= 1'b0;
    reti_p;
    wr(`IPSW_A_PRL, 8'h00);
    wr(`IPSW_A_IEL, 8'h10);
    rd(`IPSW_A_STBY, 8'h08);
    // Pause keeps the oscillators and ends on an enabled request
    wr(`IPSW_A_STBY, 8'h01);
    cyc(2);
    chk({12'h0, run, osc}, 16'h0007);
    rd(`IPSW_A_STBY, 8'h10);
    preq <= 6'h01;
    cyc(4);
    chk({12'h0, run, osc}, 16'h000f);
    preq <= 6'h00;
    // Oscillator stop, woken by pin b at its selected low level
    wr(`IPSW_A_CTRL, 8'h0c);
    wr(`IPSW_A_IEL, 8'h02);
    wr(`IPSW_A_FLAG, 8'h02);
    wr(`IPSW_A_STBY, 8'h02);
    cyc(2);
    chk({12'h0, run, osc}, 16'h0000);
    p7[1] <= 1'b0;
    cyc(4);
    chk({12'h0, run, osc}, 16'h000f);
    p7[1] <= 1'b1;
    wr(`IPSW_A_IEL, 8'h00);
    wr(`IPSW_A_FLAG, 8'h02);
    // Oscillator stop, woken by a low port 0 pin that is enabled
    wr(`IPSW_A_P0M, 8'h01);
    wr(`IPSW_A_IEH, 8'h02);
    wr(`IPSW_A_STBY, 8'h02);
    cyc(2);
    chk({12'h0, run, osc}, 16'h0000);
    p0 <= 8'hfe;
    cyc(4);
    chk({12'h0, run, osc}, 16'h000f);
    p0 <= 8'hff;
    wr(`IPSW_A_IEH, 8'h00);
    wr(`IPSW_A_FLAG, 8'h40);
    // Oscillator stop, left by pulling the reset pin low
    wr(`IPSW_A_STBY, 8'h02);
    cyc(2);
    rst_n <= 1'b0;
    cyc(2);
    chk({12'h0, run, osc}, 16'h000f);
    rst_n <= 1'b1;
    cyc(3);
    rd(`IPSW_A_STBY, 8'h08);
    wrap_up;
  end
endmodule

`default_nettype wire
